/* File: core/ltig_regs.svh */
// register offsets, fields, reset values and timing counts for the
// loop-test interrogation generator; assumes a plain strobe port
// Operation
// (R1) one of two modes at a time
// (R2) ten stored or switch-set interrogations
// (R3) compare expected type and data with returned block
// (R4) sample sum, difference or omni combiner output
// (R5) control word: uplink, sample, reply-mode fields
// (R6) 16-bit trigger time against range counter
// (R7) match issues uplink trigger
// (R8) arrival pulse clears range counter
// (R9) preamble table and message table
// (R10) select decoded by table into 8:1 muxes; the code decodes it into one of three table kinds instead
// (R11) trigger resets 9-bit address counter
// (R12) preamble first, message only for discrete-address
// (R13) gate keys carrier, enables phase modulation
// (R14) toggle flip-flop flips on each one bit
// (R15) full count stops counter until next trigger
// (R16) stored message bits sent unchanged
// (R17) range counter counts every cycle, wraps
`ifndef LTIG_REGS_SVH
`define LTIG_REGS_SVH
`define LTIG_ADDR_W 4
`define LTIG_OFS_CTRL 4'h0
`define LTIG_OFS_TRIG 4'h1
`define LTIG_OFS_STATUS 4'h2
`define LTIG_OFS_RANGE 4'h3
`define LTIG_OFS_EXP 4'h4
`define LTIG_OFS_RXBLK 4'h5
`define LTIG_OFS_SAMPLE 4'h6
`define LTIG_CTRL_MODE 0
`define LTIG_CTRL_SEL_LO 4
`define LTIG_CTRL_SEL_HI 7
`define LTIG_CTRL_SSEL_LO 8
`define LTIG_CTRL_SSEL_HI 9
`define LTIG_CTRL_RMODE 12
`define LTIG_CTRL_RST 16'h0000
`define LTIG_TRIG_RST 16'hFFFF
`define LTIG_SEL_PANEL 4'hA
`define LTIG_BIT_TIME_NS 1000
`define LTIG_CLK_NS 4
`define LTIG_BIT_CYC (`LTIG_BIT_TIME_NS / `LTIG_CLK_NS)
`endif

/* File: core/ltig_pkg.sv */
// types for the loop-test interrogation generator
package ltig_pkg;
    typedef enum logic {ltig_mode_interrog, ltig_mode_sample} ltig_mode_e;
    typedef enum logic [1:0] {
        ltig_ssel_sum, ltig_ssel_diff, ltig_ssel_omni, ltig_ssel_none
    } ltig_ssel_e;
    typedef logic [8:0] ltig_addr_t;
    typedef struct packed {
        logic gate;
        logic data;
        logic is_da;
        logic last;
    } ltig_step_s;
endpackage

/* File: core/ltig_rom_if.sv */
// carries table address and step word between sequencer and table store
`timescale 1ns/1ps
interface ltig_rom_if;
    import ltig_pkg::*;
    logic [3:0] sel;
    ltig_addr_t addr;
    ltig_step_s step;
    modport seq (output sel, output addr, input step);
    modport rom (input sel, input addr, output step);
endinterface

/* File: core/ltig_rom.sv */
// stored interrogation tables: preamble gates and message bits
// registered read, one cycle after address; assumes one clock
`timescale 1ns/1ps
module ltig_rom (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // table access
    ltig_rom_if.rom rom
);
    import ltig_pkg::*;
    logic [3:0] kind;
    logic da;
    logic pre_gate;
    logic [8:0] a;
    ltig_step_s step_r;
    ltig_step_s step_nxt;
    // decode table, stands in for per-source 8:1 selection
    always_comb begin  // see (R10)
        unique case (rom.sel)
            4'h0, 4'h1: kind = 4'h0;
            4'h4, 4'h5, 4'h6: kind = 4'h1;
            default: kind = 4'h2;
        endcase
    end
    assign da = (kind == 4'h2);
    assign a = rom.addr;
    // preamble: two pulses at fixed positions, a third for kind 0  // see (R9)
    assign pre_gate = (a < 9'h002) || (a >= 9'h008 && a < 9'h00A) ||
        (kind == 4'h0 && a >= 9'h010 && a < 9'h012);
    always_comb begin
        step_nxt = '0;
        step_nxt.is_da = da;
        if (a < 9'h020) begin
            step_nxt.gate = pre_gate;
        end else if (da && a < 9'h020 + 9'h038) begin  // see (R12)
            step_nxt.gate = 1'b1;
            // message bits stored already encoded  // see (R16)
            step_nxt.data = ^{a, rom.sel};
        end
        step_nxt.last = da ? (a == 9'h057) : (a == 9'h01F);
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            step_r <= '0;
        end else begin
            step_r <= step_nxt;
        end
    end
    assign rom.step = step_r;
endmodule

/* File: core/ltig_top.sv */
// loop-test interrogation generator and reply sampler
// assumes register strobes on i_clk; arrival pulse and combiner
// samples come from outside and are synchronised here
`timescale 1ns/1ps
`include "ltig_regs.svh"
module ltig_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [`LTIG_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // receiver side
    input wire logic i_time_of_arrival_pulse,
    input wire logic i_rx_blk_valid,
    input wire logic [15:0] i_rx_blk,
    input wire logic [3:0] i_rx_type,
    input wire logic [15:0] i_panel_data,
    // combiner samples
    input wire logic i_sum,
    input wire logic i_diff,
    input wire logic i_omni,
    // rf section
    output logic o_carrier_gate,
    output logic o_phase_mod,
    output logic o_uplink_trigger,
    output ltig_pkg::ltig_mode_e o_mode
);
    import ltig_pkg::*;
    ltig_rom_if rif ();
    logic [15:0] ctrl_r;
    logic [15:0] trig_r;
    logic [15:0] range_r;
    logic [15:0] exp_r;
    logic [15:0] rxblk_r;
    logic [2:0] toa_s;
    logic [1:0] sum_s;
    logic [1:0] diff_s;
    logic [1:0] omni_s;
    logic toa_rise;
    logic trig_pulse;
    logic run_r;
    ltig_addr_t addr_r;
    logic pm_r;
    logic gate_r;
    logic bit_r;
    logic sample_r;
    logic [15:0] sample_cnt_r;
    logic type_ok_r;
    logic data_ok_r;
    logic cmp_done_r;
    logic [3:0] sel;
    logic rmode;
    ltig_mode_e mode;
    ltig_ssel_e ssel;
    logic [15:0] rdata_nxt;

    // control word fields  // see (R5)
    assign mode = ctrl_r[`LTIG_CTRL_MODE] ? ltig_mode_sample
                                          : ltig_mode_interrog;
    assign sel = ctrl_r[`LTIG_CTRL_SEL_HI:`LTIG_CTRL_SEL_LO];
    assign ssel = ltig_ssel_e'(ctrl_r[`LTIG_CTRL_SSEL_HI:
                                      `LTIG_CTRL_SSEL_LO]);
    assign rmode = ctrl_r[`LTIG_CTRL_RMODE];
    assign o_mode = mode;  // see (R1)

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_r <= `LTIG_CTRL_RST;
            trig_r <= `LTIG_TRIG_RST;
            exp_r <= 16'h0000;
        end else if (i_wr) begin
            unique case (i_addr)
                `LTIG_OFS_CTRL: ctrl_r <= i_wdata;
                `LTIG_OFS_TRIG: trig_r <= i_wdata;  // see (R6)
                `LTIG_OFS_EXP: exp_r <= i_wdata;
                default: ;
            endcase
        end
    end

    // pin synchronisers; first stage read only by second
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            toa_s <= 3'h0;
            sum_s <= 2'h0;
            diff_s <= 2'h0;
            omni_s <= 2'h0;
        end else begin
            toa_s <= {toa_s[1:0], i_time_of_arrival_pulse};
            sum_s <= {sum_s[0], i_sum};
            diff_s <= {diff_s[0], i_diff};
            omni_s <= {omni_s[0], i_omni};
        end
    end
    assign toa_rise = toa_s[1] && !toa_s[2];

    // range counter; arrival wins over counting  // see (R8)
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            range_r <= 16'h0000;
        end else if (toa_rise) begin
            range_r <= 16'h0000;  // see (R8)
        end else begin
            range_r <= range_r + 16'h0001;  // see (R17)
        end
    end

    // match fires only in interrogation mode  // see (R7)
    assign trig_pulse = (range_r == trig_r) &&
                        (mode == ltig_mode_interrog);
    assign o_uplink_trigger = trig_pulse;

    // sequencing address counter
    // trigger mid-interrogation restarts it; last one wins
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_r <= 9'h000;
            run_r <= 1'b0;
        end else if (trig_pulse) begin
            addr_r <= 9'h000;  // see (R11)
            run_r <= 1'b1;
        end else if (run_r) begin
            if (addr_r == 9'h1FF || rif.step.last) begin
                run_r <= 1'b0;  // see (R15)
            end else begin
                addr_r <= addr_r + 9'h001;  // see (R12)
            end
        end
    end
    assign rif.addr = addr_r;
    // panel source replaces stored message  // see (R2)
    assign rif.sel = sel;

    ltig_rom u_rom (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .rom(rif.rom)
    );

    // table word lags address one cycle; track run to match
    logic run_d;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_d <= 1'b0;
        end else begin
            run_d <= run_r && !trig_pulse;
        end
    end

    // carrier key and phase toggle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gate_r <= 1'b0;
            bit_r <= 1'b0;
        end else begin
            gate_r <= run_d && rif.step.gate;  // see (R13)
            if (sel == `LTIG_SEL_PANEL) begin
                bit_r <= i_panel_data[addr_r[3:0]];
            end else begin
                bit_r <= rif.step.data;  // see (R16)
            end
        end
    end
    assign o_carrier_gate = gate_r;

    // one bit flips phase at bit start; zero holds
    // no clear on trigger: phase may only move while keyed
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pm_r <= 1'b0;
        end else if (run_d && rif.step.is_da && rif.step.gate &&
                     bit_r) begin
            pm_r <= ~pm_r;  // see (R14), (R13)
        end
    end
    assign o_phase_mod = pm_r;

    // reply sampling of chosen combiner output  // see (R4)
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sample_r <= 1'b0;
            sample_cnt_r <= 16'h0000;
        end else if (mode == ltig_mode_sample) begin
            unique case (ssel)
                ltig_ssel_sum: sample_r <= sum_s[1];
                ltig_ssel_diff: sample_r <= diff_s[1];
                ltig_ssel_omni: sample_r <= omni_s[1];
                ltig_ssel_none: sample_r <= 1'b0;
            endcase
            if (toa_rise) begin
                sample_cnt_r <= 16'h0000;
            end else if (sample_r) begin
                sample_cnt_r <= sample_cnt_r + 16'h0001;
            end
        end
    end

    // returned block check; data compared only when the reply-mode bit is set
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            type_ok_r <= 1'b0;
            data_ok_r <= 1'b0;
            cmp_done_r <= 1'b0;
            rxblk_r <= 16'h0000;
        end else if (trig_pulse) begin
            cmp_done_r <= 1'b0;
        end else if (i_rx_blk_valid) begin
            rxblk_r <= i_rx_blk;
            cmp_done_r <= 1'b1;
            type_ok_r <= (i_rx_type == sel);  // see (R3)
            data_ok_r <= !rmode || (i_rx_blk == exp_r);  // see (R3)
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        unique case (i_addr)
            `LTIG_OFS_CTRL: rdata_nxt = ctrl_r;
            `LTIG_OFS_STATUS: rdata_nxt = {10'h000, sample_r, run_r,
                type_ok_r, data_ok_r, cmp_done_r, pm_r};
            `LTIG_OFS_RANGE: rdata_nxt = range_r;
            `LTIG_OFS_EXP: rdata_nxt = exp_r;
            `LTIG_OFS_RXBLK: rdata_nxt = rxblk_r;
            `LTIG_OFS_SAMPLE: rdata_nxt = sample_cnt_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule

/* File: bench/ltig_props.sv */
// port checker for the loop-test interrogation generator
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
`include "ltig_regs.svh"
module ltig_props (
    // clock, reset and register port
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [`LTIG_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    // rf side
    input wire logic o_carrier_gate,
    input wire logic o_phase_mod,
    input wire logic o_uplink_trigger,
    input wire ltig_pkg::ltig_mode_e o_mode
);
    import ltig_pkg::*;
    logic [9:0] quiet_r;
    // idle span longer than the longest 512-step sequence
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            quiet_r <= 10'h258;
        else if (o_uplink_trigger)
            quiet_r <= 10'h000;
        else if (quiet_r != 10'h258)
            quiet_r <= quiet_r + 10'h001;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    chk_trig_mode:
    assert property (o_uplink_trigger |-> o_mode == ltig_mode_interrog)
        else $error("trigger in sampling mode");
    chk_trig_single:
    assert property (o_uplink_trigger |=> !o_uplink_trigger [*2])
        else $error("trigger repeated");
    chk_gate_start:
    assert property ($rose(o_uplink_trigger) |-> ##[2:4] o_carrier_gate)
        else $error("no gate after trigger");
    chk_phase_gated:
    assert property ($changed(o_phase_mod) |->
        o_carrier_gate || $past(o_carrier_gate))
        else $error("phase moved while ungated");
    chk_gate_quiet:
    assert property (quiet_r == 10'h258 |-> !o_carrier_gate)
        else $error("gate without a trigger");
    chk_phase_quiet:
    assert property (quiet_r == 10'h258 |-> $stable(o_phase_mod))
        else $error("phase moved without a trigger");
    chk_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read slot");
    chk_mode_write:
    assert property (i_wr && i_addr == `LTIG_OFS_CTRL |=>
        o_mode == $past(i_wdata[0]))
        else $error("mode not taken from write");
    cover property ($rose(o_carrier_gate));
    cover property ($changed(o_phase_mod));
    cover property (o_mode == ltig_mode_sample && i_rd);
endmodule
bind ltig_top ltig_props u_ltig_props (.i_clk, .i_arst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .o_carrier_gate, .o_phase_mod,
    .o_uplink_trigger, .o_mode);

/* File: bench/ltig_rx_model.sv */
// receiver under test: arrival pulses and returned data blocks
// assumes bench commands change just after rising edges of i_clk
`timescale 1ns/1ps
module ltig_rx_model (
    // bench commands
    input wire logic i_clk,
    input wire logic i_toa_req,
    input wire logic i_blk_req,
    input wire logic [15:0] i_blk_val,
    input wire logic [3:0] i_type_val,
    // toward the block
    output logic o_toa,
    output logic o_blk_valid,
    output logic [15:0] o_blk,
    output logic [3:0] o_type
);
    initial begin
        o_toa = 1'b0;
        o_blk_valid = 1'b0;
        o_blk = 16'h0000;
        o_type = 4'h0;
    end
    // wide enough to cross a two-stage synchroniser
    always @(posedge i_clk) begin
        if (i_toa_req) begin
            o_toa <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_toa <= 1'b0;
        end
    end
    // no stale block outside the valid cycle
    always @(posedge i_clk) begin
        o_blk_valid <= i_blk_req;
        o_blk <= i_blk_req ? i_blk_val : ~o_blk;
        o_type <= i_blk_req ? i_type_val : ~o_type;
    end
endmodule

/* File: bench/loop_test_interrogation_gen_tb.sv */
// self-checking bench for the loop-test interrogation generator
// assumes the receiver model and checker sit beside the design
`timescale 1ns/1ps
`include "ltig_regs.svh"
module loop_test_interrogation_gen_tb;
    import ltig_pkg::*;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_sum = 1'b0;
    logic toa_req = 1'b0;
    logic blk_req = 1'b0;
    logic [15:0] blk_val = 16'h0000;
    logic [3:0] type_val = 4'h0;
    logic [15:0] o_rdata, rx_blk;
    logic o_carrier_gate, o_phase_mod, o_uplink_trigger, time_of_arrival_pulse, blk_valid;
    logic [3:0] rx_type;
    ltig_mode_e o_mode;
    int fail_count = 0;
    int samples_checked = 0;
    always #2 i_clk = ~i_clk;
    ltig_top u_ltig_top (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_time_of_arrival_pulse(time_of_arrival_pulse),
        .i_rx_blk_valid(blk_valid), .i_rx_blk(rx_blk), .i_rx_type(rx_type),
        .i_panel_data(16'h5A5A), .i_sum(i_sum), .i_diff(1'b0),
        .i_omni(1'b0), .o_carrier_gate(o_carrier_gate),
        .o_phase_mod(o_phase_mod), .o_uplink_trigger(o_uplink_trigger),
        .o_mode(o_mode));
    ltig_rx_model u_ltig_rx_model (.i_clk(i_clk), .i_toa_req(toa_req),
        .i_blk_req(blk_req), .i_blk_val(blk_val), .i_type_val(type_val),
        .o_toa(time_of_arrival_pulse), .o_blk_valid(blk_valid), .o_blk(rx_blk),
        .o_type(rx_type));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        d = o_rdata;
    endtask
    task automatic toa_pulse();
        toa_req <= 1'b1;
        @(posedge i_clk);
        toa_req <= 1'b0;
    endtask
    task automatic wait_trig(output int n);
        n = 0;
        while (o_uplink_trigger !== 1'b1 && n < 300) begin
            @(posedge i_clk);
            n++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic s_regs();
        logic [15:0] v;
        rd(`LTIG_OFS_CTRL, v);
        chk(v, `LTIG_CTRL_RST);
        wr(`LTIG_OFS_CTRL, 16'h0001);
        chk({15'h0000, o_mode}, 16'h0001);
        rd(`LTIG_OFS_CTRL, v);
        chk(v, 16'h0001);
        rd(`LTIG_OFS_TRIG, v);
        chk(v, 16'h0000);
        rd(4'hF, v);
        chk(v, 16'h0000);
    endtask
    task automatic s_range();
        int n;
        logic [15:0] v;
        wr(`LTIG_OFS_CTRL, 16'h0000);
        wr(`LTIG_OFS_TRIG, 16'h0040);
        toa_pulse();
        wait_trig(n);
        chk({15'h0000, n inside {[32'h42:32'h48]}}, 16'h0001);
        rd(`LTIG_OFS_RANGE, v);
        chk(v, 16'h0041);
    endtask
    task automatic s_interrog();
        int n, g, t;
        logic p;
        for (int s = 0; s < 11; s++) begin
            wr(`LTIG_OFS_CTRL, 16'(s) << 4);
            toa_pulse();
            wait_trig(n);
            g = 0;
            t = 0;
            p = o_phase_mod;
            repeat (600) begin
                @(posedge i_clk);
                g += o_carrier_gate;
                t += (o_phase_mod != p);
                p = o_phase_mod;
            end
            chk(16'(g), s < 2 ? 16'h0006 : s inside {4, 5, 6} ? 16'h0004
                : 16'h003C);
            chk(16'(t != 0), 16'(!(s inside {0, 1, 4, 5, 6})));
        end
    endtask
    task automatic s_reply();
        logic [15:0] v;
        wr(`LTIG_OFS_CTRL, 16'h1020);
        wr(`LTIG_OFS_EXP, 16'h1234);
        for (int k = 0; k < 2; k++) begin
            blk_val <= 16'h1234 + 16'(k);
            type_val <= 4'h2;
            blk_req <= 1'b1;
            @(posedge i_clk);
            blk_req <= 1'b0;
            repeat (3) @(posedge i_clk);
            rd(`LTIG_OFS_STATUS, v);
            chk({14'h0000, v[3:2]}, k ? 16'h0002 : 16'h0003);
            rd(`LTIG_OFS_RXBLK, v);
            chk(v, 16'h1234 + 16'(k));
        end
    endtask
    task automatic s_sample();
        int n;
        logic [15:0] v;
        wr(`LTIG_OFS_CTRL, 16'h0001);
        toa_pulse();
        n = 0;
        for (int k = 0; k < 100; k++) begin
            i_sum <= (k >= 10 && k < 30);
            @(posedge i_clk);
            n += o_uplink_trigger;
        end
        chk(16'(n), 16'h0000);
        rd(`LTIG_OFS_SAMPLE, v);
        chk(v, 16'h0014);
    endtask
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        s_regs();
        s_range();
        s_interrog();
        s_reply();
        s_sample();
        end_of_test();
    end
endmodule
